/* hdl/gpt_pkg.sv */
// Package for the general-purpose 64-bit / dual 32-bit timer.
// Assumes a single aclk domain and an AXI4-Lite register port.
package gpt_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_GCTRL = 8'h04;
    localparam logic [7:0] OFF_LOCNT = 8'h08;
    localparam logic [7:0] OFF_HICNT = 8'h0c;
    localparam logic [7:0] OFF_LOPRD = 8'h10;
    localparam logic [7:0] OFF_HIPRD = 8'h14;
    // timer_control_reg field positions
    localparam int CTRL_LOEN_LSB = 6;
    localparam int CTRL_CLKSRC_BIT = 8;
    localparam int CTRL_HIEN_LSB = 22;
    // global_control_reg field positions
    localparam int GCTRL_LOREL_BIT = 0;
    localparam int GCTRL_HIREL_BIT = 1;
    localparam int GCTRL_MODE_LSB = 2;
    localparam int GCTRL_PSC_LSB = 8;
    localparam int GCTRL_DDR_LSB = 12;
    // Values after reset
    localparam logic [63:0] RST_COUNT = 64'h0;
    localparam logic [63:0] RST_PERIOD = 64'h0;
    localparam logic [3:0] RST_PRESCALE = 4'h0;
    localparam logic RST_CLKSRC = 1'b0;
    localparam logic RST_RELEASE = 1'b0;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        GPT_MODE_64 = 2'b00,
        GPT_MODE_UNCH = 2'b01,
        GPT_MODE_RSVD = 2'b10,
        GPT_MODE_CHAIN = 2'b11
    } gpt_mode_e;

    typedef enum logic [1:0] {
        GPT_EN_OFF = 2'b00,
        GPT_EN_ONCE = 2'b01,
        GPT_EN_CONT = 2'b10,
        GPT_EN_RSVD = 2'b11
    } gpt_ena_e;

    typedef struct packed {
        logic int_lo;
        logic dma_lo;
        logic int_hi;
        logic dma_hi;
    } gpt_evt_s;

    typedef struct packed {
        logic hit;
        logic [31:0] value;
    } gpt_step_s;
endpackage : gpt_pkg

/* hdl/gpt_timer.sv */
// General-purpose timer: one 64-bit, two chained or two unchained
// 32-bit counters, with AXI4-Lite registers.
// Assumes aclk at 125 MHz; external_clock_pin is asynchronous.
//
// Summary of operation
// - 64-bit mode runs only with both half release bits set.
// - In 64-bit and chained modes only the low enable mode matters.
// - Enable mode 0 stops counting and holds the count.
// - Enable mode 1 counts up to the period then stops.
// - Enable mode 2 counts to period, returns to zero, repeats.
// - Both releases 0 hold reset; both 1 with enable 0 is idle.
// - External clock is synchronised to the internal clock.
// - Count and period both zero: enable accepted, no increment.
// - 64-bit low word read captures high word; high read returns it.
// - Timer mode 3 selects dual 32-bit chained operation.
// - Chained: either release bit at 0 resets both timer and prescaler.
// - Chained prescaler counts inputs, pulses and clears after match.
// - Chained low counter advances once per prescaler pulse.
// - Chained low match raises interrupt and DMA; continuous clears.
// - Chained mode ignores the upper 16 control bits.
// - Timer mode 1 selects two independent 32-bit timers.
// - Unchained 4-bit prescaler uses internal clock, pulses after match.
// - Unchained high counter steps per prescaler pulse, own release.
// - Timer mode 0 is the reset default: one 64-bit counter.
// - Clock source bit: 0 internal, 1 synchronised external pin.
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module gpt_timer
    import gpt_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // External clock pin
    input wire logic external_clock_pin,
    // Timer interrupt and DMA event pulses
    output gpt_evt_s timer_events
);

    // Control and status state
    gpt_ena_e low_enable_mode;
    gpt_ena_e high_enable_mode;
    logic clock_source_select;
    logic low_half_run_release;
    logic high_half_run_release;
    gpt_mode_e timer_mode_select;
    logic [3:0] prescale_field;
    logic [3:0] divide_down_field;
    logic [63:0] count;
    logic [63:0] period;
    logic [31:0] shadow_high;
    logic pre_pulse;
    logic psc_pulse;
    logic ext_q1;
    logic ext_q2;
    logic ext_q3;

    // Bus holding registers
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;

    // Next values
    logic [63:0] next_count;
    logic [3:0] next_divide_down;
    logic next_pre_pulse;
    logic next_psc_pulse;
    logic next_hit_lo;
    logic next_hit_hi;

    // Byte-lane merge of a write
    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = data[8*i +: 8];
            end
        end
        return r;
    endfunction : wmerge

    // One step of a 32-bit up-counter against its period
    function automatic gpt_step_s step32(input logic [31:0] cnt,
                                         input logic [31:0] prd,
                                         input logic run,
                                         input logic tick,
                                         input logic cont);
        gpt_step_s r;
        r.hit = 1'b0;
        r.value = cnt;
        if (run) begin
            if (cnt == prd) begin
                if (cont) begin
                    r.value = 32'h0;
                end
            end else if (tick) begin
                r.value = cnt + 32'h1;
                r.hit = (r.value == prd);
            end
        end
        return r;
    endfunction : step32

    // Mode and enable decoding
    wire mode_chain = (timer_mode_select == GPT_MODE_CHAIN);
    wire mode_unch = (timer_mode_select == GPT_MODE_UNCH);
    wire lo_on = (low_enable_mode != GPT_EN_OFF);
    wire lo_cont = low_enable_mode[1];
    wire hi_on = (high_enable_mode != GPT_EN_OFF);
    wire hi_cont = high_enable_mode[1];
    wire both_rel = low_half_run_release & high_half_run_release;
    wire run_joint = both_rel & lo_on;
    wire run_lo_unch = low_half_run_release & lo_on;
    // high half has its own release
    wire run_hi_unch = high_half_run_release & hi_on;

    wire ext_rise = ext_q2 & ~ext_q3;
    wire tick_in = clock_source_select ? ext_rise : 1'b1;

    // 64-bit and prescaler step helpers
    wire [63:0] inc64 = count + 64'h1;
    wire wide_match = (count == period);
    wire hi_match = (count[63:32] == period[63:32]);
    wire pdiv_match = (divide_down_field == prescale_field);

    // Shared 32-bit steps
    gpt_step_s lo_chain;
    gpt_step_s lo_unch;
    gpt_step_s hi_unch;
    // low counter clocked by prescaler pulse
    assign lo_chain = step32(count[31:0], period[31:0], run_joint,
                             pre_pulse, lo_cont);
    assign lo_unch = step32(count[31:0], period[31:0], run_lo_unch,
                            tick_in, lo_cont);
    // high counter clocked by 4-bit prescaler
    assign hi_unch = step32(count[63:32], period[63:32], run_hi_unch,
                            psc_pulse, hi_cont);

    always_comb begin
        next_count = count;
        next_divide_down = divide_down_field;
        next_pre_pulse = 1'b0;
        next_psc_pulse = 1'b0;
        next_hit_lo = 1'b0;
        next_hit_hi = 1'b0;
        case (timer_mode_select)
            GPT_MODE_CHAIN: begin
                // prescaler clears and pulses after match
                if (run_joint) begin
                    if (hi_match) begin
                        next_count[63:32] = 32'h0;
                        next_pre_pulse = 1'b1;
                    end else if (tick_in) begin
                        next_count[63:32] = count[63:32] + 32'h1;
                    end
                end
                next_count[31:0] = lo_chain.value;
                next_hit_lo = lo_chain.hit;
            end
            GPT_MODE_UNCH: begin
                next_count[31:0] = lo_unch.value;
                next_hit_lo = lo_unch.hit;
                if (run_hi_unch) begin
                    if (pdiv_match) begin
                        next_divide_down = 4'h0;
                        next_psc_pulse = 1'b1;
                    end else begin
                        next_divide_down = divide_down_field + 4'h1;
                    end
                end
                next_count[63:32] = hi_unch.value;
                next_hit_hi = hi_unch.hit;
            end
            default: begin
                if (run_joint) begin
                    // zero count and period never step
                    if (wide_match) begin
                        if (lo_cont) begin
                            next_count = 64'h0;
                        end
                    end else if (tick_in) begin
                        next_count = inc64;
                        next_hit_lo = (inc64 == period);
                    end
                end
            end
        endcase
        if (!low_half_run_release) begin
            next_count[31:0] = 32'h0;
            next_hit_lo = 1'b0;
        end
        if (!high_half_run_release) begin
            next_count[63:32] = 32'h0;
            next_divide_down = 4'h0;
            next_hit_hi = 1'b0;
            next_pre_pulse = 1'b0;
            next_psc_pulse = 1'b0;
        end
        if (!mode_unch && !both_rel) begin
            next_count = 64'h0;
            next_hit_lo = 1'b0;
        end
    end

    // Register words as read back
    wire [31:0] ctrl_word = (32'(low_enable_mode) << CTRL_LOEN_LSB)
        | (32'(clock_source_select) << CTRL_CLKSRC_BIT)
        | (32'(high_enable_mode) << CTRL_HIEN_LSB);
    wire [31:0] gctrl_word = (32'(low_half_run_release) << GCTRL_LOREL_BIT)
        | (32'(high_half_run_release) << GCTRL_HIREL_BIT)
        | (32'(timer_mode_select) << GCTRL_MODE_LSB)
        | (32'(prescale_field) << GCTRL_PSC_LSB)
        | (32'(divide_down_field) << GCTRL_DDR_LSB);
    wire mode64 = !mode_chain && !mode_unch;

    // Read decode
    wire rd_lo = (s_axi_araddr == OFF_LOCNT);
    wire rd_hi = (s_axi_araddr == OFF_HICNT);
    wire rd_ok = (s_axi_araddr == OFF_CTRL) || (s_axi_araddr == OFF_GCTRL)
        || rd_lo || rd_hi || (s_axi_araddr == OFF_LOPRD)
        || (s_axi_araddr == OFF_HIPRD);
    logic [31:0] rd_word;
    always_comb begin
        case (s_axi_araddr)
            OFF_CTRL: rd_word = ctrl_word;
            OFF_GCTRL: rd_word = gctrl_word;
            OFF_LOCNT: rd_word = count[31:0];
            OFF_HICNT: rd_word = mode64 ? shadow_high : count[63:32];
            OFF_LOPRD: rd_word = period[31:0];
            OFF_HIPRD: rd_word = period[63:32];
            default: rd_word = 32'h0;
        endcase
    end
    wire ar_go = s_axi_arvalid & s_axi_arready;
    wire cap_shadow = ar_go & rd_lo & mode64;

    // Write decode
    wire wr_go = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    wire wr_ctrl = wr_go & (aw_addr_q == OFF_CTRL);
    wire wr_gctrl = wr_go & (aw_addr_q == OFF_GCTRL);
    wire wr_locnt = wr_go & (aw_addr_q == OFF_LOCNT);
    wire wr_hicnt = wr_go & (aw_addr_q == OFF_HICNT);
    wire wr_loprd = wr_go & (aw_addr_q == OFF_LOPRD);
    wire wr_hiprd = wr_go & (aw_addr_q == OFF_HIPRD);
    wire wr_ok = wr_ctrl | wr_gctrl | wr_locnt | wr_hicnt | wr_loprd
        | wr_hiprd;
    wire [31:0] new_ctrl = wmerge(ctrl_word, w_data_q, w_strb_q);
    wire [31:0] new_gctrl = wmerge(gctrl_word, w_data_q, w_strb_q);
    wire [31:0] new_locnt = wmerge(count[31:0], w_data_q, w_strb_q);
    wire [31:0] new_hicnt = wmerge(count[63:32], w_data_q, w_strb_q);
    wire [31:0] new_loprd = wmerge(period[31:0], w_data_q, w_strb_q);
    wire [31:0] new_hiprd = wmerge(period[63:32], w_data_q, w_strb_q);

    // AXI write channel handshakes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // AXI read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
            shadow_high <= 32'h0;
        end else begin
            if (ar_go) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (cap_shadow) begin
                shadow_high <= count[63:32];
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Control fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low_enable_mode <= GPT_EN_OFF;
            high_enable_mode <= GPT_EN_OFF;
            clock_source_select <= RST_CLKSRC;
            low_half_run_release <= RST_RELEASE;
            high_half_run_release <= RST_RELEASE;
            timer_mode_select <= GPT_MODE_64;
            prescale_field <= RST_PRESCALE;
            period <= RST_PERIOD;
        end else begin
            if (wr_ctrl) begin
                low_enable_mode <= gpt_ena_e'(new_ctrl[CTRL_LOEN_LSB +: 2]);
                clock_source_select <= new_ctrl[CTRL_CLKSRC_BIT];
                high_enable_mode <= gpt_ena_e'(new_ctrl[CTRL_HIEN_LSB +: 2]);
            end
            if (wr_gctrl) begin
                low_half_run_release <= new_gctrl[GCTRL_LOREL_BIT];
                high_half_run_release <= new_gctrl[GCTRL_HIREL_BIT];
                timer_mode_select <=
                    gpt_mode_e'(new_gctrl[GCTRL_MODE_LSB +: 2]);
                prescale_field <= new_gctrl[GCTRL_PSC_LSB +: 4];
            end
            if (wr_loprd) begin
                period[31:0] <= new_loprd;
            end
            if (wr_hiprd) begin
                period[63:32] <= new_hiprd;
            end
        end
    end

    // Counters, prescaler and synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= RST_COUNT;
            divide_down_field <= 4'h0;
            pre_pulse <= 1'b0;
            psc_pulse <= 1'b0;
            ext_q1 <= 1'b0;
            ext_q2 <= 1'b0;
            ext_q3 <= 1'b0;
        end else begin
            ext_q1 <= external_clock_pin;
            ext_q2 <= ext_q1;
            ext_q3 <= ext_q2;
            count[31:0] <= wr_locnt ? new_locnt : next_count[31:0];
            count[63:32] <= wr_hicnt ? new_hicnt : next_count[63:32];
            divide_down_field <= wr_gctrl ? new_gctrl[GCTRL_DDR_LSB +: 4]
                                          : next_divide_down;
            pre_pulse <= next_pre_pulse;
            psc_pulse <= next_psc_pulse;
        end
    end

    // Event outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_events <= '0;
        end else begin
            timer_events.int_lo <= next_hit_lo;
            timer_events.dma_lo <= next_hit_lo;
            timer_events.int_hi <= next_hit_hi;
            timer_events.dma_hi <= next_hit_hi;
        end
    end

endmodule : gpt_timer

/* verif/gpt_timer_checker.sv */
// Checker for the timer's bus handshakes and event pulses.
// Assumes it is bound to gpt_timer: one clock, synchronous reset.
`timescale 1ns/1ps
module gpt_timer_checker
    import gpt_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Event pulses
    input wire gpt_evt_s timer_events
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    lo_pair_a: assert property (
        timer_events.int_lo == timer_events.dma_lo)
        else $error("low interrupt and dma pulses differ");
    hi_pair_a: assert property (
        timer_events.int_hi == timer_events.dma_hi)
        else $error("high interrupt and dma pulses differ");
    hi_pulse_a: assert property (
        timer_events.int_hi |=> !timer_events.int_hi)
        else $error("high event longer than one cycle");
    after_reset_a: assert property (
        $rose(aresetn) |-> timer_events == 4'h0 && s_axi_arready
        && !s_axi_rvalid && !s_axi_bvalid)
        else $error("outputs not quiet after reset");
    rd_answer_a: assert property (ar_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer not one cycle after address");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    rd_done_a: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid && s_axi_arready)
        else $error("read not closed after handshake");
    wr_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid)
        else $error("write response late");
    wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready
        && !s_axi_wready)
        else $error("write accepted during response");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid)
        else $error("write response dropped");
endmodule : gpt_timer_checker

bind gpt_timer gpt_timer_checker u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .timer_events(timer_events));

/* verif/tb.sv */
// Self-checking bench for the general-purpose timer.
// Assumes gpt_timer with AXI4-Lite registers and a 125 MHz aclk.
`timescale 1ns/1ps
module tb import gpt_pkg::*;;
    logic aclk, aresetn, external_clock_pin;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    gpt_evt_s timer_events;
    int fail_count = 0, n_checks = 0, cyc = 0, n0;
    int lo_n = 0, hi_n = 0, lo_gap = 0, hi_gap = 0, lo_t = 0, hi_t = 0;

    gpt_timer dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .external_clock_pin(external_clock_pin),
        .timer_events(timer_events));

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // Event spacing monitor and run limit
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (timer_events.int_lo === 1'b1) begin
            lo_n <= lo_n + 1;
            lo_gap <= cyc - lo_t;
            lo_t <= cyc;
        end
        if (timer_events.int_hi === 1'b1) begin
            hi_n <= hi_n + 1;
            hi_gap <= cyc - hi_t;
            hi_t <= cyc;
        end
        if (cyc == 20000) begin
            fail_count++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    task automatic chk(input string what, input logic [63:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic ta, tw, td;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        td = 1'b0;
        while (!td) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            td = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
    endtask : wr

    task automatic rd(input logic [7:0] a);
        logic ta, td;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        td = 1'b0;
        while (!td) begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            td = s_axi_rvalid;
            d = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
        end
    endtask : rd

    task automatic rchk(input string what, input logic [7:0] a,
                        input logic [31:0] exp);
        rd(a);
        chk(what, d, exp);
    endtask : rchk

    task automatic start(input logic [31:0] g, plo, phi, c);
        wr(OFF_CTRL, 32'h0);
        wr(OFF_GCTRL, 32'h0);
        wr(OFF_GCTRL, g);
        wr(OFF_LOPRD, plo);
        wr(OFF_HIPRD, phi);
        wr(OFF_CTRL, c);
    endtask : start

    task automatic t_defaults();
        rchk("control", OFF_CTRL, 32'h0);
        rchk("global", OFF_GCTRL, 32'h0);
        rd(8'h40);
        chk("unmapped read", {resp, d}, {RESP_SLVERR, 32'h0});
        wr(8'h40, 32'h1);
        chk("unmapped write", resp, RESP_SLVERR);
        $display("test defaults done");
    endtask : t_defaults

    task automatic t_release();
        start(32'h0, 32'h64, 32'h0, 32'h80);
        repeat (20) @(posedge aclk);
        rchk("held count", OFF_LOCNT, 32'h0);
        wr(OFF_GCTRL, 32'h1);
        repeat (20) @(posedge aclk);
        rchk("half released", OFF_LOCNT, 32'h0);
        wr(OFF_CTRL, 32'h0);
        wr(OFF_GCTRL, 32'h3);
        wr(OFF_LOCNT, 32'h7);
        repeat (10) @(posedge aclk);
        rchk("disabled", OFF_LOCNT, 32'h7);
        wr(OFF_CTRL, 32'h0080_0000);
        repeat (20) @(posedge aclk);
        rchk("high enable", OFF_LOCNT, 32'h7);
        $display("test release done");
    endtask : t_release

    task automatic t_modes64();
        n0 = lo_n;
        start(32'h3, 32'd20, 32'h0, 32'h40);
        repeat (60) @(posedge aclk);
        rchk("once stop", OFF_LOCNT, 32'd20);
        chk("once events", lo_n - n0, 1);
        start(32'h3, 32'd9, 32'h0, 32'h80);
        repeat (60) @(posedge aclk);
        chk("cont gap", lo_gap, 10);
        start(32'h3, 32'h0, 32'h0, 32'h40);
        n0 = lo_n;
        repeat (20) @(posedge aclk);
        rchk("zero period", OFF_LOCNT, 32'h0);
        chk("zero events", lo_n - n0, 0);
        $display("test 64-bit modes done");
    endtask : t_modes64

    task automatic t_shadow();
        start(32'h3, 32'hffff_ffff, 32'hffff_ffff, 32'h0);
        wr(OFF_LOCNT, 32'hffff_fff0);
        wr(OFF_HICNT, 32'h0);
        wr(OFF_CTRL, 32'h80);
        rd(OFF_LOCNT);
        repeat (40) @(posedge aclk);
        rchk("shadow high", OFF_HICNT, 32'h0);
        rd(OFF_LOCNT);
        rchk("shadow next", OFF_HICNT, 32'h1);
        $display("test shadow done");
    endtask : t_shadow

    task automatic t_ext();
        start(32'h3, 32'hffff_ffff, 32'h0, 32'h180);
        repeat (20) @(posedge aclk);
        rchk("ext idle", OFF_LOCNT, 32'h0);
        repeat (10) begin
            external_clock_pin <= 1'b1;
            repeat (4) @(posedge aclk);
            external_clock_pin <= 1'b0;
            repeat (4) @(posedge aclk);
        end
        repeat (10) @(posedge aclk);
        rchk("ext count", OFF_LOCNT, 32'd10);
        wr(OFF_CTRL, 32'h100);
        external_clock_pin <= 1'b1;
        repeat (4) @(posedge aclk);
        external_clock_pin <= 1'b0;
        repeat (4) @(posedge aclk);
        wr(OFF_CTRL, 32'h180);
        external_clock_pin <= 1'b1;
        repeat (10) @(posedge aclk);
        rchk("ext resume", OFF_LOCNT, 32'd11);
        $display("test external clock done");
    endtask : t_ext

    task automatic t_dual();
        start(32'hf, 32'h3, 32'h2, 32'hffff_0080);
        repeat (80) @(posedge aclk);
        chk("chain gap", lo_gap, 9);
        wr(OFF_GCTRL, 32'hd);
        repeat (30) @(posedge aclk);
        rchk("chain half", OFF_LOCNT, 32'h0);
        n0 = lo_n;
        start(32'h206, 32'h5, 32'h4, 32'h0080_0040);
        repeat (80) @(posedge aclk);
        chk("unchained gap", hi_gap, 12);
        chk("low in reset", lo_n - n0, 0);
        $display("test dual modes done");
    endtask : t_dual

    initial begin
        aresetn = 1'b0;
        external_clock_pin = 1'b0;
        s_axi_awaddr = 8'h0;
        s_axi_araddr = 8'h0;
        s_axi_wdata = 32'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_defaults();
        t_release();
        t_modes64();
        t_shadow();
        t_ext();
        t_dual();
        results();
    end
endmodule : tb
